// ### common/are_pkg.sv
// shared constants for the converter result and event block
package are_pkg;
   // register byte offsets
   localparam logic [7:0] ARE_OFS_EIM_RES = 8'h40;
   localparam logic [7:0] ARE_OFS_CH7_RES = 8'h54;
   localparam logic [7:0] ARE_OFS_STATUS = 8'h78;
   localparam logic [7:0] ARE_OFS_MASK = 8'h7C;
   localparam logic [7:0] ARE_OFS_CTRL = 8'h84;
   localparam logic [7:0] ARE_OFS_PEND = 8'h88;
   // result register field positions
   localparam int ARE_BIT_OVERRUN = 18;
   localparam int ARE_BIT_VALID = 17;
   localparam int ARE_BIT_HOLD = 16;
   localparam int ARE_RES_W = 12;
   // status word bit positions
   localparam int ARE_NUM_CH = 8;
   localparam int ARE_IS_EIM = 8;
   localparam int ARE_IS_ESM = 9;
   localparam int ARE_IS_W = 10;
   // pad widths for short conversions
   localparam int ARE_PAD8 = 4;
   localparam int ARE_PAD10 = 2;
   localparam logic [31:0] ARE_ZERO = 32'h0000_0000;
   localparam logic [11:0] ARE_RES_RST = 12'h000;
   // names of the two conversion widths
   typedef enum logic {ARE_CONV8, ARE_CONV10} are_conv_t;
endpackage : are_pkg

// ### common/are_res_if.sv
// carries one result register's update and access events
`timescale 1ns/1ps
interface are_res_if;
   logic load;
   logic last_repeat;
   logic conv10;
   logic [9:0] raw;
   logic sw_mode;
   logic rd;
   logic wr_hold;
   logic wr_data;
   logic [31:0] word;
   logic valid_rise;
   modport owner (input load, last_repeat, conv10, raw, sw_mode, rd,
      wr_hold, wr_data, output word, valid_rise);
   modport user (output load, last_repeat, conv10, raw, sw_mode, rd,
      wr_hold, wr_data, input word, valid_rise);
endinterface : are_res_if

// ### rtl/are_result_event.sv
// result registers, events, dma requests and interrupt for the converter
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
//
// Overview of operation
// - overrun flag bit 18 set when new result overwrites unread data
// - overrun only set in overwrite mode outside software mode
// - any read of the result register clears its overrun flag
// - valid flag bit 17 set on each hardware result update
// - valid flag cleared when software reads the register
// - mode bit 16: zero overwrites, one waits for read
// - 8-bit result sits in bits 11:4, low four bits zero
// - 10-bit result sits in bits 11:2, low two bits zero
// - bits 31:19 and 15:12 always read zero
// - exceptional result valid only after all repeats are done
// - dma requests for sequence, exceptional sequence, channels 0 to 7
// - channel 7 dma request on each result update, except in software mode
// - interrupt sources exceptional sequence, interrupt meas, channels 0-7
// - interrupt on each result update, except in software mode
// - status bits 7:0 channels, bit 8 interrupt meas, bit 9 exceptional sequence
module are_result_event
   import are_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // results from the sequencer
   input wire logic CH7_LOAD,
   input wire logic EIM_LOAD,
   input wire logic EIM_LAST_REPEAT,
   input wire logic CONV10,
   input wire logic [9:0] RAW_RESULT,
   input wire logic SW_MODE,
   // events of channels 0 to 6 and the sequences, one-cycle pulses
   input wire logic [ARE_NUM_CH-2:0] CH_DONE_LOW,
   input wire logic SEQ_DONE,
   input wire logic ESM_DONE,
   // dma requests and interrupt
   output logic DMA_SEQ_REQ,
   output logic DMA_ESM_REQ,
   output logic [ARE_NUM_CH-1:0] DMA_CH_REQ,
   output logic IRQ
);
   logic [ARE_IS_W-1:0] status;
   logic [ARE_IS_W-1:0] mask;
   logic [ARE_IS_W-1:0] events;
   logic [ARE_IS_W-1:0] w1c;
   logic acc;
   logic ack;
   logic wr_ok;
   logic rd_ch7;
   logic rd_eim;
   logic [31:0] next_readdata;

   are_res_if ch7_if ();
   are_res_if eim_if ();

   // one-cycle wait so the read data come from a register
   assign acc = (AVS_READ || AVS_WRITE) && !ack;
   assign wr_ok = AVS_WRITE && acc && AVS_BYTEENABLE[2];
   assign rd_ch7 = AVS_READ && acc && (AVS_ADDRESS == ARE_OFS_CH7_RES);
   assign rd_eim = AVS_READ && acc && (AVS_ADDRESS == ARE_OFS_EIM_RES);

   // channel seven result register
   assign ch7_if.load = CH7_LOAD;
   assign ch7_if.last_repeat = 1'b1;
   assign ch7_if.conv10 = CONV10;
   assign ch7_if.raw = RAW_RESULT;
   assign ch7_if.sw_mode = SW_MODE;
   assign ch7_if.rd = rd_ch7;
   assign ch7_if.wr_hold = wr_ok && (AVS_ADDRESS == ARE_OFS_CH7_RES);
   assign ch7_if.wr_data = AVS_WRITEDATA[ARE_BIT_HOLD];

   are_result_reg u_ch7 (
      .clk(CLK),
      .arst_n(ARST_N),
      .rif(ch7_if.owner)
   );

   // exceptional measurement result register
   assign eim_if.load = EIM_LOAD;
   // valid only after the last repeat
   assign eim_if.last_repeat = EIM_LAST_REPEAT;
   assign eim_if.conv10 = CONV10;
   assign eim_if.raw = RAW_RESULT;
   assign eim_if.sw_mode = SW_MODE;
   assign eim_if.rd = rd_eim;
   assign eim_if.wr_hold = wr_ok && (AVS_ADDRESS == ARE_OFS_EIM_RES);
   assign eim_if.wr_data = AVS_WRITEDATA[ARE_BIT_HOLD];

   are_result_reg u_eim (
      .clk(CLK),
      .arst_n(ARST_N),
      .rif(eim_if.owner)
   );

   always_comb
   begin
      events = '0;
      events[ARE_NUM_CH-2:0] = CH_DONE_LOW & {(ARE_NUM_CH-1){!SW_MODE}};
      events[ARE_NUM_CH-1] = ch7_if.valid_rise;
      events[ARE_IS_EIM] = eim_if.valid_rise;
      events[ARE_IS_ESM] = ESM_DONE && !SW_MODE;
   end

   // write one to clear
   assign w1c = AVS_WRITE && acc && (AVS_ADDRESS == ARE_OFS_STATUS)
      ? {AVS_WRITEDATA[ARE_IS_W-1:8] & {(ARE_IS_W-8){AVS_BYTEENABLE[1]}},
         AVS_WRITEDATA[7:0] & {8{AVS_BYTEENABLE[0]}}}
      : '0;

   // sticky status, a new event wins over a clear
   genvar gi;
   generate
      for (gi = 0; gi < ARE_IS_W; gi++)
      begin : g_sts
         always_ff @(posedge CLK or negedge ARST_N)
         begin
            if (!ARST_N)
               status[gi] <= 1'b0;
            else if (events[gi])
               status[gi] <= 1'b1;
            else if (w1c[gi])
               status[gi] <= 1'b0;
         end
      end
   endgenerate

   // interrupt mask, byte lanes honoured
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         mask <= '0;
      else if (AVS_WRITE && acc && (AVS_ADDRESS == ARE_OFS_MASK))
      begin
         if (AVS_BYTEENABLE[0])
            mask[7:0] <= AVS_WRITEDATA[7:0];
         if (AVS_BYTEENABLE[1])
            mask[ARE_IS_W-1:8] <= AVS_WRITEDATA[ARE_IS_W-1:8];
      end
   end

   // level interrupt while an unmasked bit is set
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         IRQ <= 1'b0;
      else
         IRQ <= |((status | events) & mask);
   end

   // dma request pulses outside software mode, one cycle per done event or channel 7 result update
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         DMA_SEQ_REQ <= 1'b0;
         DMA_ESM_REQ <= 1'b0;
         DMA_CH_REQ <= '0;
      end
      else
      begin
         DMA_SEQ_REQ <= SEQ_DONE && !SW_MODE;
         DMA_ESM_REQ <= ESM_DONE && !SW_MODE;
         DMA_CH_REQ <= events[ARE_NUM_CH-1:0];
      end
   end

   // read mux; unmapped addresses read zero and writes are dropped
   always_comb
   begin
      next_readdata = ARE_ZERO;
      case (AVS_ADDRESS)
         ARE_OFS_CH7_RES: next_readdata = ch7_if.word;
         ARE_OFS_EIM_RES: next_readdata = eim_if.word;
         ARE_OFS_STATUS: next_readdata[ARE_IS_W-1:0] = status;
         ARE_OFS_MASK: next_readdata[ARE_IS_W-1:0] = mask;
         ARE_OFS_CTRL: next_readdata[0] = SW_MODE;
         ARE_OFS_PEND: next_readdata[ARE_IS_W-1:0] = status & mask;
         default: next_readdata = ARE_ZERO;
      endcase
   end

   // answer handshake: waitrequest drops one cycle after the request
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         ack <= 1'b0;
      else
         ack <= acc;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         AVS_WAITREQUEST <= 1'b1;
      else
         AVS_WAITREQUEST <= !acc;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         AVS_READDATA <= ARE_ZERO;
      else if (AVS_READ && acc)
         AVS_READDATA <= next_readdata;
   end
endmodule : are_result_event

// ### rtl/are_result_reg.sv
// one result register with valid, overrun and hold-until-read flags
`timescale 1ns/1ps
module are_result_reg
   import are_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register events
   are_res_if.owner rif
);
   logic [ARE_RES_W-1:0] value;
   logic valid;
   logic overrun;
   logic hold;
   logic pending;
   logic [9:0] pend_raw;
   logic pend_c10;
   logic take;
   logic [9:0] src_raw;
   logic src_c10;
   logic [ARE_RES_W-1:0] aligned;

   // hold mode blocks replacement while unread data sits here
   // hold until read
   assign take = (rif.load && rif.last_repeat && !(hold && valid))
      || (pending && !valid);
   assign src_raw = (rif.load && rif.last_repeat && !(hold && valid))
      ? rif.raw : pend_raw;
   assign src_c10 = (rif.load && rif.last_repeat && !(hold && valid))
      ? rif.conv10 : pend_c10;

   always_comb
   begin
      if (src_c10)
         aligned = {src_raw, {ARE_PAD10{1'b0}}};
      else
         aligned = {src_raw[7:0], {ARE_PAD8{1'b0}}};
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         hold <= 1'b0;
      else if (rif.wr_hold)
         hold <= rif.wr_data;
   end

   // one-deep wait slot for a result refused in hold mode
   // any update empties the slot, so an older result never returns later
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pending <= 1'b0;
         pend_raw <= 10'h000;
         pend_c10 <= 1'b0;
      end
      else if (rif.load && rif.last_repeat && hold && valid)
      begin
         pending <= 1'b1;
         pend_raw <= rif.raw;
         pend_c10 <= rif.conv10;
      end
      else if (take)
         pending <= 1'b0;
   end

   // result field
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         value <= ARE_RES_RST;
      else if (take)
         value <= aligned;
   end

   // valid set on update, set wins over read
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         valid <= 1'b0;
      else if (take)
         valid <= 1'b1;
      else if (rif.rd)
         valid <= 1'b0;
   end

   // overrun only in overwrite mode and not software mode
   // cleared by read; an update landing together with a read sets no overrun
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         overrun <= 1'b0;
      else if (take && valid && !rif.rd && !hold && !rif.sw_mode)
         overrun <= 1'b1;
      else if (rif.rd)
         overrun <= 1'b0;
   end

   always_comb
   begin
      rif.word = ARE_ZERO;
      rif.word[ARE_RES_W-1:0] = value;
      rif.word[ARE_BIT_HOLD] = hold;
      rif.word[ARE_BIT_VALID] = valid;
      rif.word[ARE_BIT_OVERRUN] = overrun;
   end

   // pulse on each update, even with valid already set, suppressed in software mode
   assign rif.valid_rise = take && !rif.sw_mode;
endmodule : are_result_reg

// ### tb/are_dma_model.sv
// far side model: dma controller counting the requests it serves
`timescale 1ns/1ps
module are_dma_model
   import are_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // requests from the block
   input wire logic dma_seq,
   input wire logic dma_esm,
   input wire logic [ARE_NUM_CH-1:0] dma_ch,
   // served count per line: channels, then sequence, then exceptional
   output logic [9:0][7:0] req_cnt
);
   logic [9:0] req;

   // one vector so the counters share one loop
   assign req = {dma_esm, dma_seq, dma_ch};

   // prompt request service
   // every pulse is taken at once; stalls would hide lost results
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         req_cnt <= '0;
      else
         for (int i = 0; i < 10; i++)
            req_cnt[i] <= req_cnt[i] + 8'(req[i]);
endmodule : are_dma_model

// ### tb/are_result_event_chk.sv
// assertions for the converter result and event block
`timescale 1ns/1ps
module are_chk
   import are_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // register bus
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   // events and requests
   input wire logic CH7_LOAD,
   input wire logic SW_MODE,
   input wire logic [ARE_NUM_CH-2:0] CH_DONE_LOW,
   input wire logic SEQ_DONE,
   input wire logic ESM_DONE,
   input wire logic DMA_SEQ_REQ,
   input wire logic DMA_ESM_REQ,
   input wire logic [ARE_NUM_CH-1:0] DMA_CH_REQ
);
   logic unread;
   logic rd_res;
   logic rd7;

   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   // a read completes in this cycle
   assign rd_res = AVS_READ && !AVS_WAITREQUEST;
   assign rd7 = rd_res && AVS_ADDRESS == ARE_OFS_CH7_RES;

   // conservative unread marker: a load onto unread data may stay quiet
   always_ff @(posedge CLK or negedge ARST_N)
      if (!ARST_N)
         unread <= 1'h0;
      else if (CH7_LOAD)
         unread <= 1'h1;
      else if (rd7)
         unread <= 1'h0;

   // bus answers one cycle after taking a request, for one cycle only
   wait_answer_a: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("access not answered in one cycle");
   wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low too long");

   // result reads carry no reserved bits
   rsvd_zero_a: assert property (
      rd_res && (AVS_ADDRESS == ARE_OFS_CH7_RES
      || AVS_ADDRESS == ARE_OFS_EIM_RES) |-> AVS_READDATA[31:19] == '0
      && AVS_READDATA[15:12] == '0)
      else $error("reserved result bits not zero");

   // requests follow fresh results, never in software mode
   ch7_dma_a: assert property (
      CH7_LOAD && !SW_MODE && !unread && !AVS_READ
      |-> ##[1:2] DMA_CH_REQ[7])
      else $error("channel seven request missing");
   sw_no_dma_a: assert property (
      SW_MODE && $past(SW_MODE) && $past(SW_MODE, 2)
      |-> DMA_CH_REQ == '0 && !DMA_SEQ_REQ && !DMA_ESM_REQ)
      else $error("request in software mode");

   // channel zero, sequence and exceptional done events reach their own request lines
   ch0_dma_a: assert property (
      CH_DONE_LOW[0] && !SW_MODE |-> ##[1:2] DMA_CH_REQ[0])
      else $error("channel zero request missing");
   seq_dma_a: assert property (
      SEQ_DONE && !SW_MODE |-> ##[1:2] DMA_SEQ_REQ)
      else $error("sequence request missing");
   esm_dma_a: assert property (
      ESM_DONE && !SW_MODE |-> ##[1:2] DMA_ESM_REQ)
      else $error("exceptional sequence request missing");
endmodule : are_chk

bind are_result_event are_chk u_are_chk (.CLK, .ARST_N, .AVS_ADDRESS,
   .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .CH7_LOAD,
   .SW_MODE, .CH_DONE_LOW, .SEQ_DONE, .ESM_DONE, .DMA_SEQ_REQ,
   .DMA_ESM_REQ, .DMA_CH_REQ);

// ### tb/test_are_result_event.sv
// self-checking bench for the converter result and event block
`timescale 1ns/1ps
module test_are_result_event;
   import are_pkg::*;
   logic CLK = 1'h0;
   logic ARST_N = 1'h0;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic AVS_READ = 1'h0;
   logic AVS_WRITE = 1'h0;
   logic [31:0] AVS_WRITEDATA = ARE_ZERO;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic CH7_LOAD = 1'h0;
   logic EIM_LOAD = 1'h0;
   logic EIM_LAST_REPEAT = 1'h0;
   logic CONV10 = 1'h0;
   logic [9:0] RAW_RESULT = 10'h000;
   logic SW_MODE = 1'h0;
   logic [6:0] CH_DONE_LOW = 7'h00;
   logic SEQ_DONE = 1'h0;
   logic ESM_DONE = 1'h0;
   logic DMA_SEQ_REQ;
   logic DMA_ESM_REQ;
   logic [7:0] DMA_CH_REQ;
   logic IRQ;
   logic [9:0][7:0] req_cnt;
   logic [31:0] q;
   int error_cnt = 0;
   int tests_run = 0;

   // 40 MHz system clock
   always #12.5 CLK = ~CLK;

   // byte lanes tied on: every write is a full word
   are_result_event u_are_result_event (.CLK, .ARST_N, .AVS_ADDRESS,
      .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA, .AVS_WAITREQUEST, .CH7_LOAD, .EIM_LOAD,
      .EIM_LAST_REPEAT, .CONV10, .RAW_RESULT, .SW_MODE, .CH_DONE_LOW,
      .SEQ_DONE, .ESM_DONE, .DMA_SEQ_REQ, .DMA_ESM_REQ, .DMA_CH_REQ, .IRQ);
   are_dma_model u_are_dma_model (.clk(CLK), .arst_n(ARST_N),
      .dma_seq(DMA_SEQ_REQ), .dma_esm(DMA_ESM_REQ), .dma_ch(DMA_CH_REQ),
      .req_cnt);

   task automatic test_done;
      $display("tests %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : check

   // one access; an idle edge follows so requests never merge
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'h0 && n < 20);
      r = AVS_READDATA;
      AVS_READ <= 1'h0;
      AVS_WRITE <= 1'h0;
      if (n == 20)
      begin
         error_cnt++;
         test_done;
      end
      @(posedge CLK);
   endtask : bus

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, ARE_ZERO, q);
      check(q, e);
   endtask : rd_chk

   // irq is registered, so let two edges land before looking
   task automatic irq_chk(input logic [31:0] e);
      repeat (2) @(posedge CLK);
      check(32'(IRQ), e);
   endtask : irq_chk

   // expected word: flags {overrun, valid, hold}, value left-aligned
   function automatic logic [31:0] rw(input logic [2:0] f,
      input logic c10, input logic [9:0] v);
      rw = {13'h0000, f, 4'h0, c10 ? {v, 2'h0} : {v[7:0], 4'h0}};
   endfunction : rw

   task automatic ld(input logic c7, input logic c10, input logic [9:0] v);
      CH7_LOAD <= c7;
      EIM_LOAD <= !c7;
      CONV10 <= c10;
      RAW_RESULT <= v;
      @(posedge CLK);
      CH7_LOAD <= 1'h0;
      EIM_LOAD <= 1'h0;
      repeat (3) @(posedge CLK);
   endtask : ld

   task automatic t_res;
      ld(1'h1, 1'h0, 10'h3A5);
      rd_chk(ARE_OFS_CH7_RES, rw(3'h2, 1'h0, 10'h3A5));
      rd_chk(ARE_OFS_CH7_RES, rw(3'h0, 1'h0, 10'h3A5));
      ld(1'h1, 1'h1, 10'h3A5);
      check(32'(req_cnt[7]), 32'h0000_0002);
      ld(1'h1, 1'h1, 10'h1C6);
      rd_chk(ARE_OFS_CH7_RES, rw(3'h6, 1'h1, 10'h1C6));
      rd_chk(ARE_OFS_CH7_RES, rw(3'h0, 1'h1, 10'h1C6));
      $display("result test done");
   endtask : t_res

   task automatic t_hold;
      bus(1'h1, ARE_OFS_CH7_RES, 32'h0001_0000, q);
      ld(1'h1, 1'h0, 10'h033);
      ld(1'h1, 1'h0, 10'h044);
      rd_chk(ARE_OFS_CH7_RES, rw(3'h3, 1'h0, 10'h033));
      rd_chk(ARE_OFS_CH7_RES, rw(3'h3, 1'h0, 10'h044));
      rd_chk(ARE_OFS_CH7_RES, rw(3'h1, 1'h0, 10'h044));
      bus(1'h1, ARE_OFS_CH7_RES, ARE_ZERO, q);
      $display("hold test done");
   endtask : t_hold

   task automatic t_sw;
      logic [7:0] n;
      SW_MODE <= 1'h1;
      @(posedge CLK);
      n = req_cnt[7];
      ld(1'h1, 1'h0, 10'h055);
      ld(1'h1, 1'h0, 10'h066);
      rd_chk(ARE_OFS_CH7_RES, rw(3'h2, 1'h0, 10'h066));
      check(32'(req_cnt[7]), 32'(n));
      SW_MODE <= 1'h0;
      $display("software mode test done");
   endtask : t_sw

   task automatic t_eim;
      bus(1'h1, ARE_OFS_STATUS, 32'h0000_03FF, q);
      ld(1'h0, 1'h0, 10'h077);
      rd_chk(ARE_OFS_EIM_RES, ARE_ZERO);
      EIM_LAST_REPEAT <= 1'h1;
      ld(1'h0, 1'h1, 10'h288);
      EIM_LAST_REPEAT <= 1'h0;
      rd_chk(ARE_OFS_EIM_RES, rw(3'h2, 1'h1, 10'h288));
      rd_chk(ARE_OFS_STATUS, 32'h0000_0100);
      irq_chk(ARE_ZERO);
      bus(1'h1, ARE_OFS_MASK, 32'h0000_0100, q);
      irq_chk(32'h0000_0001);
      rd_chk(ARE_OFS_PEND, 32'h0000_0100);
      rd_chk(ARE_OFS_CTRL, ARE_ZERO);
      bus(1'h1, ARE_OFS_STATUS, 32'h0000_0100, q);
      irq_chk(ARE_ZERO);
      rd_chk(8'hF0, ARE_ZERO);
      $display("interrupt test done");
   endtask : t_eim

   task automatic t_evt;
      for (int i = 0; i < 9; i++)
      begin
         {ESM_DONE, SEQ_DONE, CH_DONE_LOW} <= 9'h001 << i;
         @(posedge CLK);
         {ESM_DONE, SEQ_DONE, CH_DONE_LOW} <= 9'h000;
         repeat (3) @(posedge CLK);
         check(32'(req_cnt[i < 7 ? i : i + 1]), 32'h0000_0001);
      end
      rd_chk(ARE_OFS_STATUS, 32'h0000_027F);
      $display("event test done");
   endtask : t_evt

   initial
   begin
      repeat (4) @(posedge CLK);
      ARST_N <= 1'h1;
      rd_chk(ARE_OFS_CH7_RES, ARE_ZERO);
      t_res;
      t_hold;
      t_sw;
      t_eim;
      t_evt;
      test_done;
   end
endmodule : test_are_result_event
